// ### design/scc_clock_ctrl.sv
// Purpose: System clock source selection, start-up timing and fail-safe switching
// Assumes: All pin and oscillator inputs are sampled synchronously to aclk
// Notes:   Selected clock is reproduced as a sampled level on sys_clk_out
//
// How it works
// - Clock mode comes from a 3-bit strap, latched once, read-only to software.
// - External clock mode takes the input pin clock; port A bit 4 is GPIO.
// - RC clock-out mode drives system clock divided by four on port A bit 4.
// - RC I/O mode runs from RC network and frees port A bit 4.
// - Internal clock-out mode drives clock/4 on bit 4, frees bit 5.
// - Internal I/O mode frees both port A bit 4 and bit 5.
// - A software select bit picks configured external source or internal oscillator.
// - Two internal sources exist: 8 MHz high and 31 kHz low frequency.
// - Crystal gain modes enable the start-up timer, extending reset before execution.
// - Start-up timer counts 1024 input pin periods after POR, wake or power-up timer.
// - While the start-up timer counts, execution stays suspended.
// - External clock mode skips the start-up count entirely.
// - Stopping the external clock halts the core with state kept; restart resumes.
// - Fail-safe monitor detects lost external clock and switches to internal oscillator.
// - Start into an internal oscillator waits a CPU start-up delay of 5 us.
// - Low to high frequency internal switch waits about 1 us.
// - Oscillator fail flag sets on failure switch and stays until software clears.

`timescale 1ns/1ps
`default_nettype none

module scc_clock_ctrl #(
	parameter int unsigned FAIL_TIMEOUT = scc_pkg::FAIL_TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite slave
	input  wire logic [scc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output var  logic                      s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output var  logic                      s_axi_wready,
	output var  logic [1:0]                s_axi_bresp,
	output var  logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [scc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output var  logic                      s_axi_arready,
	output var  logic [31:0]               s_axi_rdata,
	output var  logic [1:0]                s_axi_rresp,
	output var  logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Configuration strap and reset sources
	input  wire logic [2:0]                config_mode,
	input  wire logic                      por_event,
	input  wire logic                      wake_event,
	input  wire logic                      power_up_timer_expired,
	input  wire logic                      power_up_timer_enable,
	// Clock sources
	input  wire logic                      osc_input_pin,
	input  wire logic                      high_freq_internal_osc,
	input  wire logic                      low_freq_internal_osc,
	// Port logic requests for shared pins
	input  wire logic                      gpio_a4_out,
	input  wire logic                      gpio_a4_oe,
	input  wire logic                      gpio_a5_out,
	input  wire logic                      gpio_a5_oe,
	// Shared pins
	output var  logic                      port_a_bit4_pin_out,
	output var  logic                      port_a_bit4_pin_oe,
	output var  logic                      port_a_bit5_pin_out,
	output var  logic                      port_a_bit5_pin_oe,
	// Core side
	output var  logic                      sys_clk_out,
	output var  logic                      core_run,
	output var  logic                      oscillator_startup_timer_active,
	output var  logic                      oscillator_fail_flag
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic is_crystal(input logic [2:0] m);
		return (m == scc_pkg::MODE_LOW_XTAL) || (m == scc_pkg::MODE_MED_XTAL) ||
		       (m == scc_pkg::MODE_HIGH_XTAL);
	endfunction

	function automatic logic is_internal(input logic [2:0] m);
		return (m == scc_pkg::MODE_INT_CLKOUT) || (m == scc_pkg::MODE_INT_IO);
	endfunction

	function automatic logic reg_mapped(input logic [scc_pkg::ADDR_W-1:0] a);
		return (a == scc_pkg::OFF_CTRL) || (a == scc_pkg::OFF_STATUS) ||
		       (a == scc_pkg::OFF_MODE);
	endfunction

	function automatic logic src_lvl(input scc_pkg::scc_src_t s, input logic e,
	                                 input logic l, input logic h);
		case (s)
			scc_pkg::SRC_LF: return l;
			scc_pkg::SRC_HF: return h;
			default:         return e;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// State declarations
	// ----------------------------------------------------------------
	logic                       aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [scc_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0]                wdata_q, wdata_d, rdata_q, rdata_d;
	logic                       wstrb0_q, wstrb0_d;
	logic                       awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic                       bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]                 bresp_q, bresp_d, rresp_q, rresp_d;
	logic [2:0]                 ctrl_q, ctrl_d;
	logic                       fail_flag_q, fail_flag_d;
	logic [2:0]                 mode_q, mode_d;
	scc_pkg::scc_state_t        state_q, state_d;
	logic [10:0]                cnt_q, cnt_d;
	logic                       run_q, run_d, warm_q, warm_d;
	logic                       osc_prev_q, fail_active_q, fail_active_d;
	logic [15:0]                idle_q, idle_d;
	scc_pkg::scc_src_t          cur_q, cur_d, tgt;
	logic [7:0]                 settle_q, settle_d;
	logic                       sys_clk_q, sys_clk_d;
	logic [1:0]                 div_q, div_d;
	logic                       a4_out_q, a4_out_d, a4_oe_q, a4_oe_d;
	logic                       a5_out_q, a5_out_d, a5_oe_q, a5_oe_d;
	logic                       osc_rise, trig, fail_event, do_write, use_int;

	assign osc_rise   = osc_input_pin & ~osc_prev_q;
	assign trig       = por_event | wake_event | (power_up_timer_enable & power_up_timer_expired);
	// Internal source is chosen by strap, select bit or fail-safe takeover
	assign use_int    = is_internal(mode_q) | ctrl_q[scc_pkg::CTRL_SEL_BIT] | fail_active_q;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	always_comb begin
		aw_hold_d   = aw_hold_q;
		awaddr_d    = awaddr_q;
		w_hold_d    = w_hold_q;
		wdata_d     = wdata_q;
		wstrb0_d    = wstrb0_q;
		bvalid_d    = bvalid_q;
		bresp_d     = bresp_q;
		rvalid_d    = rvalid_q;
		rdata_d     = rdata_q;
		rresp_d     = rresp_q;
		ctrl_d      = ctrl_q;
		fail_flag_d = fail_flag_q;
		do_write    = aw_hold_q & w_hold_q & ~bvalid_q;
		if (s_axi_awvalid && awready_q) begin
			aw_hold_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_hold_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb0_d = s_axi_wstrb[0];
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (do_write) begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = reg_mapped(awaddr_q) ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
			if (awaddr_q == scc_pkg::OFF_CTRL && wstrb0_q) begin
				ctrl_d = wdata_q[2:0];
			end
			// Write one to clear the fail flag
			if (awaddr_q == scc_pkg::OFF_STATUS && wstrb0_q && wdata_q[scc_pkg::STAT_FAIL_BIT]) begin
				fail_flag_d = 1'b0;
			end
		end
		// A new failure beats a clear in the same cycle
		if (fail_event) begin
			fail_flag_d = 1'b1;
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d  = reg_mapped(s_axi_araddr) ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				scc_pkg::OFF_CTRL:   rdata_d = {29'h0, ctrl_q};
				scc_pkg::OFF_STATUS: rdata_d = {27'h0, warm_q, cur_q == scc_pkg::SRC_HF,
				                                cur_q != scc_pkg::SRC_EXT, run_q, fail_flag_q};
				scc_pkg::OFF_MODE:   rdata_d = {29'h0, mode_q};
				default:             rdata_d = 32'h0;
			endcase
		end
		awready_d = ~aw_hold_d & ~bvalid_d;
		wready_d  = ~w_hold_d & ~bvalid_d;
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q   <= 1'b0;
			awaddr_q    <= '0;
			w_hold_q    <= 1'b0;
			wdata_q     <= 32'h0;
			wstrb0_q    <= 1'b0;
			awready_q   <= 1'b1;
			wready_q    <= 1'b1;
			arready_q   <= 1'b1;
			bvalid_q    <= 1'b0;
			bresp_q     <= scc_pkg::RESP_OKAY;
			rvalid_q    <= 1'b0;
			rdata_q     <= 32'h0;
			rresp_q     <= scc_pkg::RESP_OKAY;
			ctrl_q      <= scc_pkg::CTRL_RST;
			fail_flag_q <= 1'b0;
		end else begin
			aw_hold_q   <= aw_hold_d;
			awaddr_q    <= awaddr_d;
			w_hold_q    <= w_hold_d;
			wdata_q     <= wdata_d;
			wstrb0_q    <= wstrb0_d;
			awready_q   <= awready_d;
			wready_q    <= wready_d;
			arready_q   <= arready_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
			rvalid_q    <= rvalid_d;
			rdata_q     <= rdata_d;
			rresp_q     <= rresp_d;
			ctrl_q      <= ctrl_d;
			fail_flag_q <= fail_flag_d;
		end
	end

	// ----------------------------------------------------------------
	// Start-up sequencing
	// ----------------------------------------------------------------
	always_comb begin
		mode_d  = mode_q;
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			scc_pkg::ST_LOAD: begin
				// Strap is caught once after reset release
				mode_d  = config_mode;
				state_d = scc_pkg::ST_START;
			end
			scc_pkg::ST_START: begin
				cnt_d = 11'h0;
				if (use_int) begin
					state_d = scc_pkg::ST_CPU;
				end else if (is_crystal(mode_q)) begin
					state_d = scc_pkg::ST_WARM;
				end else begin
					state_d = scc_pkg::ST_RUN;
				end
			end
			scc_pkg::ST_WARM: begin
				if (fail_active_q) begin
					state_d = scc_pkg::ST_CPU;
					cnt_d   = 11'h0;
				end else if (osc_rise) begin
					if (cnt_q == scc_pkg::WARM_TERM) begin
						state_d = scc_pkg::ST_RUN;
					end else begin
						cnt_d = cnt_q + 11'h1;
					end
				end
			end
			scc_pkg::ST_CPU: begin
				if (cnt_q == scc_pkg::CPU_TERM) begin
					state_d = scc_pkg::ST_RUN;
				end else begin
					cnt_d = cnt_q + 11'h1;
				end
			end
			// A halted external clock freezes the core with its state kept; core_run stays set
			scc_pkg::ST_RUN: state_d = scc_pkg::ST_RUN;
			default: state_d = scc_pkg::ST_LOAD;
		endcase
		if (trig && state_q != scc_pkg::ST_LOAD) begin
			state_d = scc_pkg::ST_START;
		end
		run_d = (state_d == scc_pkg::ST_RUN);
		warm_d = (state_d == scc_pkg::ST_WARM);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q  <= scc_pkg::MODE_RST;
			state_q <= scc_pkg::ST_LOAD;
			cnt_q   <= 11'h0;
			run_q   <= 1'b0;
			warm_q  <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			state_q <= state_d;
			cnt_q   <= cnt_d;
			run_q   <= run_d;
			warm_q  <= warm_d;
		end
	end

	// ----------------------------------------------------------------
	// Fail-safe monitor, source multiplexer and pins
	// ----------------------------------------------------------------
	always_comb begin
		idle_d        = (osc_rise || fail_active_q) ? 16'h0 : idle_q + 16'h1;
		fail_event    = 1'b0;
		fail_active_d = fail_active_q;
		if (!is_internal(mode_q) && ctrl_q[scc_pkg::CTRL_MON_BIT] && !fail_active_q &&
		    state_q != scc_pkg::ST_LOAD && idle_q == 16'(FAIL_TIMEOUT - 1)) begin
			fail_event    = 1'b1;
			fail_active_d = 1'b1;
		end
		// Two internal sources, high or low frequency
		tgt = use_int ? (ctrl_q[scc_pkg::CTRL_HF_BIT] ? scc_pkg::SRC_HF : scc_pkg::SRC_LF)
		              : scc_pkg::SRC_EXT;
		settle_d = settle_q;
		if (cur_q == scc_pkg::SRC_LF && tgt == scc_pkg::SRC_HF) begin
			if (settle_q != scc_pkg::SWITCH_TERM) begin
				settle_d = settle_q + 8'h1;
			end
		end else begin
			settle_d = 8'h0;
		end
		cur_d = cur_q;
		if (tgt != cur_q && !src_lvl(tgt, osc_input_pin, low_freq_internal_osc,
		    high_freq_internal_osc) && (!src_lvl(cur_q, osc_input_pin, low_freq_internal_osc,
		    high_freq_internal_osc) || fail_active_q) &&
		    (settle_d == scc_pkg::SWITCH_TERM || cur_q != scc_pkg::SRC_LF ||
		    tgt != scc_pkg::SRC_HF)) begin
			cur_d = tgt;
		end
		sys_clk_d = src_lvl(cur_d, osc_input_pin, low_freq_internal_osc,
		                    high_freq_internal_osc);
		div_d = (sys_clk_d && !sys_clk_q) ? div_q + 2'h1 : div_q;
		case (mode_q)
			scc_pkg::MODE_RC_CLKOUT, scc_pkg::MODE_INT_CLKOUT: begin
				a4_out_d = div_q[1];
				a4_oe_d  = 1'b1;
			end
			scc_pkg::MODE_EXT_CLK, scc_pkg::MODE_RC_IO, scc_pkg::MODE_INT_IO: begin
				a4_out_d = gpio_a4_out;
				a4_oe_d  = gpio_a4_oe;
			end
			default: begin
				a4_out_d = 1'b0;
				a4_oe_d  = 1'b0;
			end
		endcase
		a5_out_d = is_internal(mode_q) ? gpio_a5_out : 1'b0;
		a5_oe_d  = is_internal(mode_q) ? gpio_a5_oe : 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_prev_q    <= 1'b0;
			idle_q        <= 16'h0;
			fail_active_q <= 1'b0;
			cur_q         <= scc_pkg::SRC_EXT;
			settle_q      <= 8'h0;
			sys_clk_q     <= 1'b0;
			div_q         <= 2'h0;
			a4_out_q      <= 1'b0;
			a4_oe_q       <= 1'b0;
			a5_out_q      <= 1'b0;
			a5_oe_q       <= 1'b0;
		end else begin
			osc_prev_q    <= osc_input_pin;
			idle_q        <= idle_d;
			fail_active_q <= fail_active_d;
			cur_q         <= cur_d;
			settle_q      <= settle_d;
			sys_clk_q     <= sys_clk_d;
			div_q         <= div_d;
			a4_out_q      <= a4_out_d;
			a4_oe_q       <= a4_oe_d;
			a5_out_q      <= a5_out_d;
			a5_oe_q       <= a5_oe_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_arready = arready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign port_a_bit4_pin_out = a4_out_q;
	assign port_a_bit4_pin_oe  = a4_oe_q;
	assign port_a_bit5_pin_out = a5_out_q;
	assign port_a_bit5_pin_oe  = a5_oe_q;
	assign sys_clk_out         = sys_clk_q;
	assign core_run            = run_q;
	assign oscillator_startup_timer_active = warm_q;
	assign oscillator_fail_flag = fail_flag_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_fail_seen;
		fail_event ##1 fail_flag_q;
	endsequence

	sequence s_warm_release;
		(state_q == scc_pkg::ST_WARM && cnt_q == scc_pkg::WARM_TERM && osc_rise && !trig &&
		 !fail_active_q) ##1 core_run;
	endsequence

	a_mode_locked: assert property ((state_q != scc_pkg::ST_LOAD) |=> $stable(mode_q))
		else $error("clock mode changed after capture");
	a_a4_clkout: assert property ((mode_q == scc_pkg::MODE_RC_CLKOUT ||
		mode_q == scc_pkg::MODE_INT_CLKOUT) |=> port_a_bit4_pin_oe &&
		port_a_bit4_pin_out == $past(div_q[1]))
		else $error("port A bit 4 not driving divided clock");
	a_a5_release: assert property ((mode_q == scc_pkg::MODE_INT_IO) |=>
		port_a_bit5_pin_oe == $past(gpio_a5_oe) && port_a_bit4_pin_oe == $past(gpio_a4_oe))
		else $error("port A pins not released to GPIO");
	a_warm_hold: assert property ((state_q == scc_pkg::ST_WARM) |-> !core_run)
		else $error("core running during start-up count");
	a_warm_release: assert property (($rose(core_run) && $past(state_q) == scc_pkg::ST_WARM) |->
		$past(cnt_q) == scc_pkg::WARM_TERM)
		else $error("start-up count released early");
	a_warm_done: assert property ((state_q == scc_pkg::ST_WARM && cnt_q == scc_pkg::WARM_TERM &&
		osc_rise && !trig && !fail_active_q) |-> s_warm_release)
		else $error("start-up count did not release");
	a_ext_nodelay: assert property ((state_q == scc_pkg::ST_START && !use_int &&
		mode_q == scc_pkg::MODE_EXT_CLK && !trig) |=> core_run)
		else $error("external clock mode delayed start");
	a_cpu_delay: assert property (($rose(core_run) && $past(state_q) == scc_pkg::ST_CPU) |->
		$past(cnt_q) == scc_pkg::CPU_TERM)
		else $error("CPU start-up delay too short");
	a_fail_flag: assert property (fail_event |-> s_fail_seen)
		else $error("fail flag not set on clock loss");
	a_fail_switch: assert property ((fail_active_q && cur_q == scc_pkg::SRC_EXT &&
		!src_lvl(tgt, osc_input_pin, low_freq_internal_osc, high_freq_internal_osc)) |=>
		cur_q != scc_pkg::SRC_EXT)
		else $error("fail-safe did not pick internal source");
	a_mux_glitch: assert property ($changed(cur_q) |-> !sys_clk_q)
		else $error("source changed while clock high");
	a_hf_settle: assert property (($past(cur_q) == scc_pkg::SRC_LF && cur_q == scc_pkg::SRC_HF) |->
		settle_q == scc_pkg::SWITCH_TERM)
		else $error("low to high switch too early");

endmodule

`default_nettype wire

// ### common/scc_pkg.sv
// Purpose: Shared constants and types for the system clock source control block
// Assumes: 100 MHz bus clock, AXI4-Lite register access with 32-bit data
// Notes:   All offsets are byte addresses of aligned 32-bit words

package scc_pkg;

	// ----------------------------------------------------------------
	// Bus and register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] OFF_CTRL       = 12'h000;
	localparam logic [11:0] OFF_STATUS     = 12'h004;
	localparam logic [11:0] OFF_MODE       = 12'h008;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// Control fields
	localparam int          CTRL_SEL_BIT   = 0;
	localparam int          CTRL_HF_BIT    = 1;
	localparam int          CTRL_MON_BIT   = 2;
	localparam logic [2:0]  CTRL_RST       = 3'h6;

	// Status fields
	localparam int          STAT_FAIL_BIT  = 0;
	localparam int          STAT_RUN_BIT   = 1;
	localparam int          STAT_INT_BIT   = 2;
	localparam int          STAT_HF_BIT    = 3;
	localparam int          STAT_WARM_BIT  = 4;

	// ----------------------------------------------------------------
	// Clock modes of the configuration field
	// ----------------------------------------------------------------
	localparam logic [2:0]  MODE_EXT_CLK   = 3'h0;
	localparam logic [2:0]  MODE_LOW_XTAL  = 3'h1;
	localparam logic [2:0]  MODE_MED_XTAL  = 3'h2;
	localparam logic [2:0]  MODE_HIGH_XTAL = 3'h3;
	localparam logic [2:0]  MODE_RC_CLKOUT = 3'h4;
	localparam logic [2:0]  MODE_RC_IO     = 3'h5;
	localparam logic [2:0]  MODE_INT_CLKOUT = 3'h6;
	localparam logic [2:0]  MODE_INT_IO    = 3'h7;
	localparam logic [2:0]  MODE_RST       = 3'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          HF_OSC_KHZ     = 8000;
	localparam int          LF_OSC_KHZ     = 31;
	localparam int          WARM_EDGES     = 1024;
	localparam int          CPU_START_NS   = 5000;
	localparam int          CPU_START_CYC  = (CPU_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SWITCH_NS      = 1000;
	localparam int          SWITCH_CYC     = (SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          FAIL_TIMEOUT_CYC = 256;
	localparam logic [10:0] WARM_TERM      = 11'(WARM_EDGES - 1);
	localparam logic [10:0] CPU_TERM       = 11'(CPU_START_CYC - 1);
	localparam logic [7:0]  SWITCH_TERM    = 8'(SWITCH_CYC - 1);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_EXT, SRC_LF, SRC_HF} scc_src_t;
	typedef enum logic [2:0] {ST_LOAD, ST_START, ST_WARM, ST_CPU, ST_RUN} scc_state_t;

endpackage

// ### bench/scc_osc_model.sv
// Purpose: External oscillator model driving the oscillator input pin
// Assumes: Half period counted in aclk cycles
// Notes:   Pin rests low while stopped, as a halted oscillator would
`timescale 1ns/1ps
`default_nettype none
module scc_osc_model #(
	parameter int HALF = 2
) (
	// Clock and control
	input  wire logic aclk,
	input  wire logic run,
	// Oscillator pin
	output var  logic osc_pin
);
	int cnt = 0;
	initial osc_pin = 1'b0;
	always @(posedge aclk) begin
		cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
		if (!run) osc_pin <= 1'b0;
		else if (cnt == HALF - 1) osc_pin <= ~osc_pin;
	end
endmodule
`default_nettype wire

// ### bench/system_clock_source_control_tb_top.sv
// Purpose: Self-checking bench for the system clock source control block
// Assumes: AXI4-Lite master tasks, oscillator model with a 4-cycle period
// Notes:   Fail timeout shortened to 16 cycles
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control_tb_top;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, por_event = 0, wake_event = 0, osc_run = 1;
	logic power_up_timer_expired = 0, power_up_timer_enable = 0, osc_input_pin;
	logic high_freq_internal_osc = 0, low_freq_internal_osc = 0, gpio_a4_out = 0;
	logic gpio_a4_oe = 1, gpio_a5_out = 0, gpio_a5_oe = 1, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, port_a_bit4_pin_out, port_a_bit4_pin_oe;
	logic port_a_bit5_pin_out, port_a_bit5_pin_oe, sys_clk_out, core_run;
	logic oscillator_startup_timer_active, oscillator_fail_flag;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  config_mode = 0;
	int          mismatches = 0, check_count = 0, n, lf_cnt = 0;
	always #5 aclk = ~aclk;
	// Internal oscillators: fast one every cycle, slow one every 32 cycles
	always @(posedge aclk) begin
		high_freq_internal_osc <= ~high_freq_internal_osc;
		lf_cnt <= lf_cnt + 1;
		low_freq_internal_osc <= lf_cnt[5];
	end
	scc_osc_model #(.HALF(2)) i_osc (.aclk, .run(osc_run), .osc_pin(osc_input_pin));
	scc_clock_ctrl #(.FAIL_TIMEOUT(16)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .config_mode, .por_event, .wake_event,
		.power_up_timer_expired, .power_up_timer_enable, .osc_input_pin, .high_freq_internal_osc,
		.low_freq_internal_osc, .gpio_a4_out, .gpio_a4_oe, .gpio_a5_out, .gpio_a5_oe,
		.port_a_bit4_pin_out, .port_a_bit4_pin_oe, .port_a_bit5_pin_out, .port_a_bit5_pin_oe,
		.sys_clk_out, .core_run, .oscillator_startup_timer_active, .oscillator_fail_flag);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic timeout(input int k);
		if (k >= 9000) begin
			mismatches++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 9000);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		timeout(k);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 9000);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		timeout(k);
	endtask
	task automatic do_reset(input logic [2:0] m);
		aresetn <= 1'b0;
		config_mode <= m;
		gpio_a4_out <= m[0];
		gpio_a5_out <= ~m[0];
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic wait_run(output int k);
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (core_run !== 1'b1 && k < 9000);
		timeout(k);
	endtask
	initial begin
		for (int m = 0; m < 8; m++) begin
			do_reset(3'(m));
			repeat (10) @(posedge aclk);
			check(oscillator_startup_timer_active, m inside {[1:3]});
			check(core_run, m inside {0, 4, 5});
			check(port_a_bit4_pin_oe, !(m inside {[1:3]}));
			check(port_a_bit5_pin_oe, m > 5);
			check(port_a_bit5_pin_out, m == 6);
			if (m inside {0, 5, 7}) check(port_a_bit4_pin_out, gpio_a4_out);
			if (m == 4) begin
				n = 0;
				d[0] = port_a_bit4_pin_out;
				repeat (80) begin
					@(posedge aclk);
					n += (port_a_bit4_pin_out !== d[0]);
					d[0] = port_a_bit4_pin_out;
				end
				check(n inside {[9:11]}, 1);
			end
			rd(scc_pkg::OFF_MODE, d, r);
			check(d, m);
			wait_run(n);
			if (m inside {[1:3]}) check(n inside {[4000:4150]}, 1);
			if (m > 5) check(n inside {[480:505]}, 1);
		end
		do_reset(3'h2);
		wait_run(n);
		for (int t = 0; t < 3; t++) begin
			{power_up_timer_enable, power_up_timer_expired} <= {2{t == 2}};
			por_event <= t == 0;
			wake_event <= t == 1;
			@(posedge aclk);
			{power_up_timer_enable, power_up_timer_expired, por_event, wake_event} <= 4'h0;
			repeat (3) @(posedge aclk);
			check({core_run, oscillator_startup_timer_active}, 2'h1);
			wait_run(n);
			check(n inside {[4050:4150]}, 1);
		end
		do_reset(3'h0);
		wait_run(n);
		rd(scc_pkg::OFF_CTRL, d, r);
		check(d, 32'h6);
		rd(12'h0fc, d, r);
		check(r, scc_pkg::RESP_SLVERR);
		wr(scc_pkg::OFF_MODE, 32'h7, r);
		check(r, scc_pkg::RESP_OKAY);
		rd(scc_pkg::OFF_MODE, d, r);
		check(d, 0);
		wr(scc_pkg::OFF_CTRL, 32'h1, r);
		repeat (100) @(posedge aclk);
		wr(scc_pkg::OFF_CTRL, 32'h3, r);
		rd(scc_pkg::OFF_STATUS, d, r);
		check(d[3:2], 2'h1);
		repeat (300) @(posedge aclk);
		rd(scc_pkg::OFF_STATUS, d, r);
		check(d[3:2], 2'h3);
		wr(scc_pkg::OFF_CTRL, 32'h0, r);
		osc_run <= 1'b0;
		repeat (60) @(posedge aclk);
		check({oscillator_fail_flag, sys_clk_out, core_run}, 3'h1);
		osc_run <= 1'b1;
		repeat (20) @(posedge aclk);
		wr(scc_pkg::OFF_CTRL, 32'h4, r);
		osc_run <= 1'b0;
		n = 0;
		while (oscillator_fail_flag !== 1'b1 && n < 9000) begin
			@(posedge aclk);
			n++;
		end
		timeout(n);
		check(n < 40, 1);
		repeat (70) @(posedge aclk);
		rd(scc_pkg::OFF_STATUS, d, r);
		check(d[2:0], 3'h7);
		wr(scc_pkg::OFF_STATUS, 32'h1, r);
		repeat (2) @(posedge aclk);
		check({oscillator_fail_flag, core_run}, 2'h1);
		finish_test();
	end
endmodule
`default_nettype wire
